// ==== hw/ptm_defs.vh ====
// constants for the transmit test-mode control block
`ifndef PTM_DEFS_VH
`define PTM_DEFS_VH
`define PTM_ADDR_CTRL     8'h00
`define PTM_ADDR_AUTONEG  8'h04
`define PTM_ADDR_TEST     8'h08
`define PTM_ADDR_LOOP     8'h0C
`define PTM_ADDR_STATUS   8'h10
`define PTM_CTRL_RST      32'h0000_0000
`define PTM_AUTONEG_RST   32'h0000_0001
`define PTM_TEST_RST      32'h0000_0000
`define PTM_LOOP_RST      32'h0000_0002
`define PTM_BIT_SPD       0
`define PTM_BIT_AUTONEG_ENABLE_BIT     0
`define PTM_BIT_AN_FRC    1
`define PTM_BIT_AN_LOW    2
`define PTM_BIT_TXDIS     4
`define PTM_BIT_RLB_EN    0
`define PTM_BIT_RLB_SUP   1
`define PTM_MODE_NORMAL   2'h0
`define PTM_MODE_ALT      2'h1
`define PTM_MODE_DROOP    2'h2
`define PTM_MODE_IDLE     2'h3
`define PTM_SYM_ZERO      2'h0
`define PTM_SYM_PLUS      2'h1
`define PTM_SYM_MINUS     2'h3
`define PTM_DROOP_RUN     5'h0A
`define PTM_DROOP_LEN     5'h14
`define PTM_PD_SETTLE     4'h8
`define PTM_RESP_OKAY     2'h0
`define PTM_RESP_SLVERR   2'h2
`endif

// ==== hw/ptm_pattern_gen.v ====
// compliance pattern generator for the transmit symbol stream
`timescale 1ns/1ps
`include "ptm_defs.vh"
module ptm_pattern_gen
(
    input  wire       clk,
    input  wire       arst_n,
    input  wire [1:0] mode,
    input  wire       restart,
    output reg  [1:0] pat_sym
);
    reg [4:0] pos_q;
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pos_q <= 5'h00;
        end
        else if (restart)
        begin
            pos_q <= 5'h00;
        end
        else if (mode == `PTM_MODE_ALT)
        begin
            pos_q <= {4'h0, ~pos_q[0]};
        end
        else if (pos_q == `PTM_DROOP_LEN - 5'h01)
        begin
            pos_q <= 5'h00;
        end
        else
        begin
            pos_q <= pos_q + 5'h01;
        end
    end
    always @*
    begin
        case (mode)
            `PTM_MODE_ALT:
                pat_sym = pos_q[0] ? `PTM_SYM_MINUS : `PTM_SYM_PLUS;
            `PTM_MODE_DROOP:
                pat_sym = (pos_q < `PTM_DROOP_RUN) ? `PTM_SYM_PLUS
                                                   : `PTM_SYM_MINUS;
            default:
                pat_sym = `PTM_SYM_ZERO;
        endcase
    end
endmodule // ptm_pattern_gen

// ==== hw/ptm_tx_test_ctrl.v ====
// transmit test-mode, power-down sequencing, remote loopback and swing control
`timescale 1ns/1ps
`include "ptm_defs.vh"
// Behaviour
// - test mode 1 sends +1,-1 alternately and nothing else.
// - test mode 2 sends ten +1 then ten -1 symbols, repeating forever.
// - test mode 3 transmits normally as timing master with idle signalling only; the block passes tx_sym_in through and does not force idle.
// - a test mode only replaces the transmit symbols; all other paths stay normal.
// - transmit-disable mode keeps both paths running but sends only zero symbols.
// - a readable ready bit shows that soft power-down has really been reached.
// - writing zero to the power-down request leaves power-down and the disable mode.
// - with remote loopback on, line receive data is sent back out on the line.
// - with the swing strap high at reset, only the low transmit level is used.
// - in remote loopback with suppress set (default), line data is not given to the MAC.
// - with the strap low, the high level is allowed but the low level stays selectable.
module ptm_tx_test_ctrl
(
    input  wire        clk,
    input  wire        arst_n,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [1:0]  tx_sym_in,
    input  wire [1:0]  rx_sym_in,
    input  wire        rx_valid_in,
    input  wire        high_swing_select_pin,
    output reg  [1:0]  tx_sym_out,
    output reg  [1:0]  mac_rx_sym,
    output reg         mac_rx_valid,
    output reg         tx_high_swing,
    output reg         tx_master_force,
    output reg         phy_powered_down
);
    reg        soft_powerdown_request_q;
    reg        soft_powerdown_ready_q;
    reg [3:0]  pd_cnt_q;
    reg        autoneg_enable_bit_q;
    reg        autoneg_forced_config_q;
    reg        autoneg_low_swing_q;
    reg [1:0]  tx_test_mode_select_q;
    reg        tx_disable_mode_enable_q;
    reg        remote_loop_enable_q;
    reg        remote_loop_rx_suppress_q;
    reg        strap_s1_q;
    reg        strap_s2_q;
    reg        strap_taken_q;
    reg [1:0]  strap_arm_q;
    reg        low_only_q;
    reg [1:0]  mode_prev_q;
    reg        aw_got_q;
    reg        w_got_q;
    reg [7:0]  aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0]  w_strb_q;
    wire [1:0] pat_sym;
    wire       wr_fire;
    wire       mode_change;
    wire [31:0] ctrl_wr;
    reg  [1:0] tx_sel;

    // byte-lane merge so partial writes leave untouched lanes alone
    function [31:0] ptm_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  strb;
        integer i;
        begin
            ptm_merge = old_v;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    ptm_merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
    endfunction

    function ptm_mapped;
        input [7:0] a;
        begin
            ptm_mapped = (a == `PTM_ADDR_CTRL) || (a == `PTM_ADDR_AUTONEG) ||
                         (a == `PTM_ADDR_TEST) || (a == `PTM_ADDR_LOOP) ||
                         (a == `PTM_ADDR_STATUS);
        end
    endfunction

    assign wr_fire     = aw_got_q && w_got_q && !s_axi_bvalid;
    assign mode_change = (tx_test_mode_select_q != mode_prev_q) || soft_powerdown_request_q;
    assign ctrl_wr     = ptm_merge({31'h0000_0000, soft_powerdown_request_q},
                                   w_data_q, w_strb_q);

    ptm_pattern_gen u_pat
    (
        .clk     (clk),
        .arst_n  (arst_n),
        .mode    (tx_test_mode_select_q),
        .restart (mode_change),
        .pat_sym (pat_sym)
    );

    // write channels taken in either order, response after both
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_got_q      <= 1'b0;
            w_got_q       <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PTM_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_q      <= 1'b1;
                aw_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_q      <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= ptm_mapped(aw_addr_q) ? `PTM_RESP_OKAY : `PTM_RESP_SLVERR;
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // register writes; the power-down sequence itself is software's duty
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            soft_powerdown_request_q  <= 1'b0;
            autoneg_enable_bit_q      <= 1'b1;
            autoneg_forced_config_q   <= 1'b0;
            autoneg_low_swing_q       <= 1'b0;
            tx_test_mode_select_q     <= `PTM_MODE_NORMAL;
            tx_disable_mode_enable_q  <= 1'b0;
            remote_loop_enable_q      <= 1'b0;
            remote_loop_rx_suppress_q <= 1'b1;
        end
        else if (wr_fire)
        begin
            case (aw_addr_q)
                `PTM_ADDR_CTRL:
                begin
                    soft_powerdown_request_q <= ctrl_wr[`PTM_BIT_SPD];
                    if (w_strb_q[0] && !w_data_q[`PTM_BIT_SPD])
                        tx_disable_mode_enable_q <= 1'b0;
                end
                `PTM_ADDR_AUTONEG:
                if (w_strb_q[0])
                begin
                    autoneg_enable_bit_q    <= w_data_q[`PTM_BIT_AUTONEG_ENABLE_BIT];
                    autoneg_forced_config_q <= w_data_q[`PTM_BIT_AN_FRC];
                    autoneg_low_swing_q     <= w_data_q[`PTM_BIT_AN_LOW];
                end
                `PTM_ADDR_TEST:
                if (w_strb_q[0])
                begin
                    tx_test_mode_select_q    <= w_data_q[1:0];
                    tx_disable_mode_enable_q <= w_data_q[`PTM_BIT_TXDIS];
                end
                `PTM_ADDR_LOOP:
                if (w_strb_q[0])
                begin
                    remote_loop_enable_q      <= w_data_q[`PTM_BIT_RLB_EN];
                    remote_loop_rx_suppress_q <= w_data_q[`PTM_BIT_RLB_SUP];
                end
                default:
                begin
                end
            endcase
        end
    end

    // read channel: one cycle after the address, unmapped answers slverr
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `PTM_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= ptm_mapped(s_axi_araddr) ? `PTM_RESP_OKAY : `PTM_RESP_SLVERR;
            case (s_axi_araddr)
                `PTM_ADDR_CTRL:    s_axi_rdata <= {31'h0000_0000, soft_powerdown_request_q};
                `PTM_ADDR_AUTONEG: s_axi_rdata <= {29'h0000_0000, autoneg_low_swing_q,
                                                   autoneg_forced_config_q,
                                                   autoneg_enable_bit_q};
                `PTM_ADDR_TEST:    s_axi_rdata <= {27'h0000_0000, tx_disable_mode_enable_q,
                                                   2'b00, tx_test_mode_select_q};
                `PTM_ADDR_LOOP:    s_axi_rdata <= {30'h0000_0000, remote_loop_rx_suppress_q,
                                                   remote_loop_enable_q};
                `PTM_ADDR_STATUS:  s_axi_rdata <= {30'h0000_0000, low_only_q,
                                                   soft_powerdown_ready_q};
                default:           s_axi_rdata <= 32'h0000_0000;
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // power-down ready after the path has drained a few cycles
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pd_cnt_q               <= 4'h0;
            soft_powerdown_ready_q <= 1'b0;
            mode_prev_q            <= `PTM_MODE_NORMAL;
        end
        else
        begin
            mode_prev_q <= tx_test_mode_select_q;
            if (!soft_powerdown_request_q)
            begin
                pd_cnt_q               <= 4'h0;
                soft_powerdown_ready_q <= 1'b0;
            end
            else if (pd_cnt_q == `PTM_PD_SETTLE - 4'h1)
                soft_powerdown_ready_q <= 1'b1;
            else
                pd_cnt_q <= pd_cnt_q + 4'h1;
        end
    end

    // strap is sampled once after reset release, through two flops
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            strap_s1_q    <= 1'b0;
            strap_s2_q    <= 1'b0;
            strap_taken_q <= 1'b0;
            strap_arm_q   <= 2'b00;
            low_only_q    <= 1'b1;
        end
        else
        begin
            strap_s1_q  <= high_swing_select_pin;
            strap_s2_q  <= strap_s1_q;
            strap_arm_q <= {strap_arm_q[0], 1'b1};
            // only the second stage is read; it holds a real pin sample once armed
            if (!strap_taken_q && strap_arm_q[1])
            begin
                strap_taken_q <= 1'b1;
                low_only_q    <= strap_s2_q;
            end
        end
    end

    // symbol substitution; test-mode idle relies on the normal tx stream
    always @*
    begin
        if (soft_powerdown_request_q || tx_disable_mode_enable_q)
            tx_sel = `PTM_SYM_ZERO;
        else if (tx_test_mode_select_q == `PTM_MODE_ALT ||
                 tx_test_mode_select_q == `PTM_MODE_DROOP)
            tx_sel = pat_sym;
        else if (remote_loop_enable_q)
            tx_sel = rx_valid_in ? rx_sym_in : `PTM_SYM_ZERO;
        else
            tx_sel = tx_sym_in;
    end

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_sym_out       <= `PTM_SYM_ZERO;
            mac_rx_sym       <= `PTM_SYM_ZERO;
            mac_rx_valid     <= 1'b0;
            tx_high_swing    <= 1'b0;
            tx_master_force  <= 1'b0;
            phy_powered_down <= 1'b0;
        end
        else
        begin
            tx_sym_out       <= tx_sel;
            mac_rx_sym       <= rx_sym_in;
            mac_rx_valid     <= rx_valid_in &&
                                (!soft_powerdown_request_q || tx_disable_mode_enable_q) &&
                                !(remote_loop_enable_q && remote_loop_rx_suppress_q);
            tx_high_swing    <= !low_only_q && !autoneg_low_swing_q;
            tx_master_force  <= tx_test_mode_select_q == `PTM_MODE_IDLE;
            phy_powered_down <= soft_powerdown_ready_q;
        end
    end
endmodule // ptm_tx_test_ctrl

// ==== dv/ptm_chk.sv ====
// assertion checker for the transmit test-mode control block
`timescale 1ns/1ps
module ptm_chk
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  rx_sym_in,
    input wire logic        rx_valid_in,
    input wire logic [1:0]  tx_sym_out,
    input wire logic [1:0]  mac_rx_sym,
    input wire logic        mac_rx_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    wr_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("write not answered");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped early");
    wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
        else $error("read not answered");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    sym_legal_a: assert property (tx_sym_out != 2'h2)
        else $error("illegal transmit symbol");
    mac_from_rx_a: assert property (mac_rx_valid |-> $past(rx_valid_in) &&
        mac_rx_sym == $past(rx_sym_in)) else $error("mac data not from line");
endmodule // ptm_chk

bind ptm_tx_test_ctrl ptm_chk i_chk (.clk, .arst_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .rx_sym_in,
    .rx_valid_in, .tx_sym_out, .mac_rx_sym, .mac_rx_valid);

// ==== dv/ptm_link_partner.sv ====
// link partner model: sends receive frames onto the line
`timescale 1ns/1ps
module ptm_link_partner
(
    input  wire logic       clk,
    input  wire logic       start,
    input  wire logic [7:0] len,
    output wire logic [1:0] rx_sym,
    output wire logic       rx_valid
);
    logic [7:0] left_q = 8'h00;
    logic [1:0] idx_q = 2'h0;
    logic [1:0] sym_q = 2'h0;
    logic       vld_q = 1'h0;
    assign rx_sym = sym_q;
    assign rx_valid = vld_q;
    // between frames the symbol flips each cycle so a stale value never looks like data
    always @(posedge clk)
    begin
        vld_q <= left_q != 8'h00;
        idx_q <= idx_q + 2'h1;
        if (left_q != 8'h00)
        begin
            left_q <= left_q - 8'h01;
            sym_q <= idx_q == 2'h3 ? 2'h0 : (idx_q[1] ? 2'h3 : 2'h1);
        end
        else
        begin
            left_q <= start ? len : 8'h00;
            sym_q <= ~sym_q;
        end
    end
endmodule // ptm_link_partner

// ==== dv/tb.sv ====
// self-checking bench for the transmit test-mode control block
`timescale 1ns/1ps
`include "ptm_defs.vh"
module tb;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d, e; logic [1:0] r;} ptm_row_t;
    logic        clk = 0, arst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, high_swing_select_pin = 0, lp_start = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, rd;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  tx_sym_in = 0, rs;
    wire  [1:0]  rx_sym_in, s_axi_bresp, s_axi_rresp, tx_sym_out, mac_rx_sym;
    wire  [31:0] s_axi_rdata;
    wire         rx_valid_in, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire         s_axi_rvalid, mac_rx_valid, tx_high_swing, tx_master_force, phy_powered_down;
    integer      mismatches = 0, n_tests = 0, seen = 0, i, m;
    ptm_row_t    rows [0:8] = '{
        '{0, `PTM_ADDR_CTRL, 0, `PTM_CTRL_RST, `PTM_RESP_OKAY},
        '{0, `PTM_ADDR_AUTONEG, 0, `PTM_AUTONEG_RST, `PTM_RESP_OKAY},
        '{0, `PTM_ADDR_TEST, 0, `PTM_TEST_RST, `PTM_RESP_OKAY},
        '{0, `PTM_ADDR_LOOP, 0, `PTM_LOOP_RST, `PTM_RESP_OKAY},
        '{0, `PTM_ADDR_STATUS, 0, 0, `PTM_RESP_OKAY},
        '{1, `PTM_ADDR_LOOP, 0, 0, `PTM_RESP_OKAY},
        '{1, `PTM_ADDR_TEST, 32'h0000_0013, 32'h0000_0013, `PTM_RESP_OKAY},
        '{1, `PTM_ADDR_TEST, 0, 0, `PTM_RESP_OKAY},
        '{1, 8'h14, 32'h0000_0001, 0, `PTM_RESP_SLVERR}};

    ptm_tx_test_ctrl i_dut (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_sym_in, .rx_sym_in, .rx_valid_in,
        .high_swing_select_pin, .tx_sym_out, .mac_rx_sym, .mac_rx_valid, .tx_high_swing,
        .tx_master_force, .phy_powered_down);
    ptm_link_partner i_lp (.clk, .start(lp_start), .len(8'h10), .rx_sym(rx_sym_in),
        .rx_valid(rx_valid_in));

    always #12.5 clk = ~clk;
    // pcs stream cycles +1, -1, 0 so a stuck output shows up
    always @(posedge clk)
        tx_sym_in <= tx_sym_in == 2'h1 ? 2'h3 : (tx_sym_in == 2'h3 ? 2'h0 : 2'h1);

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        integer k;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (k = 0; k < 50 && !s_axi_bvalid; k++)
        begin
            @(posedge clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end
        chk("bvalid", 1, s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        integer k;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (k = 0; k < 50 && !s_axi_rvalid; k++)
        begin
            @(posedge clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end
        chk("rvalid", 1, s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    // kind 0: follows pcs, 1: follows line when valid, 2: all zero
    task watch(input integer n, input integer kind);
        logic [1:0] pt, pr;
        logic       pv;
        @(negedge clk);
        repeat (n)
        begin
            pt = tx_sym_in;
            pr = rx_sym_in;
            pv = rx_valid_in;
            @(negedge clk);
            chk("tx_sym_out", kind == 0 ? pt : (kind == 1 && pv ? pr : 2'h0), tx_sym_out);
            if (mac_rx_valid === 1'h1)
                seen++;
        end
    endtask

    task send;
        @(posedge clk);
        lp_start <= 1'h1;
        @(posedge clk);
        lp_start <= 1'h0;
    endtask

    task enter(input logic [31:0] t);
        integer k;
        axi_wr(`PTM_ADDR_CTRL, 32'h0000_0001, rs);
        axi_rd(`PTM_ADDR_STATUS, rd, rs);
        chk("ready early", 0, rd[0]);
        for (k = 0; k < 20 && rd[0] !== 1'h1; k++)
            axi_rd(`PTM_ADDR_STATUS, rd, rs);
        chk("pd ready", 1, rd[0]);
        axi_wr(`PTM_ADDR_AUTONEG, 32'h0000_0000, rs);
        axi_wr(`PTM_ADDR_AUTONEG, 32'h0000_0002, rs);
        axi_wr(`PTM_ADDR_TEST, t, rs);
    endtask

    // capture runs beside the release write so the first pattern symbol is not missed
    task pat(input integer md);
        integer k, f;
        logic [1:0] q [0:63];
        fork
            axi_wr(`PTM_ADDR_CTRL, 32'h0000_0000, rs);
            for (k = 0; k < 64; k++)
            begin
                @(negedge clk);
                q[k] = tx_sym_out;
            end
        join
        for (f = 0; f < 30 && q[f] === 2'h0; f++);
        for (k = 0; k < 30; k++)
            chk("pattern", (md == 1 ? k % 2 : (k / 10) % 2) ? 2'h3 : 2'h1, q[f+k]);
    endtask

    task final_report;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        final_report;
    end

    initial
    begin
        repeat (10) @(posedge clk);
        arst_n <= 1'h1;
        repeat (4) @(posedge clk);
        foreach (rows[i])
        begin
            if (rows[i].w)
            begin
                axi_wr(rows[i].a, rows[i].d, rs);
                chk("bresp", rows[i].r, rs);
            end
            axi_rd(rows[i].a, rd, rs);
            chk("rresp", rows[i].r, rs);
            chk("rdata", rows[i].e, rd);
        end
        chk("swing", 1, tx_high_swing);
        axi_wr(`PTM_ADDR_AUTONEG, 32'h0000_0005, rs);
        repeat (3) @(posedge clk);
        chk("swing", 0, tx_high_swing);
        axi_wr(`PTM_ADDR_AUTONEG, 32'h0000_0001, rs);
        for (m = 1; m < 3; m++)
        begin
            enter(m);
            chk("powered down", 1, phy_powered_down);
            watch(6, 2);
            pat(m);
        end
        enter(3);
        axi_wr(`PTM_ADDR_CTRL, 32'h0000_0000, rs);
        repeat (3) @(posedge clk);
        chk("master", 1, tx_master_force);
        seen = 0;
        send;
        watch(20, 0);
        chk("rx kept", 1, seen > 0);
        enter(32'h0000_0010);
        seen = 0;
        send;
        watch(20, 2);
        chk("rx in txdis", 1, seen > 0);
        axi_wr(`PTM_ADDR_CTRL, 32'h0000_0000, rs);
        axi_rd(`PTM_ADDR_TEST, rd, rs);
        chk("txdis off", 0, rd);
        repeat (3) @(posedge clk);
        watch(10, 0);
        axi_wr(`PTM_ADDR_LOOP, 32'h0000_0003, rs);
        seen = 0;
        send;
        watch(24, 1);
        chk("suppressed", 0, seen);
        axi_wr(`PTM_ADDR_LOOP, 32'h0000_0001, rs);
        seen = 0;
        send;
        watch(24, 1);
        chk("forwarded", 1, seen > 0);
        high_swing_select_pin <= 1'h1;
        arst_n <= 1'h0;
        repeat (3) @(posedge clk);
        arst_n <= 1'h1;
        repeat (6) @(posedge clk);
        chk("swing", 0, tx_high_swing);
        axi_rd(`PTM_ADDR_STATUS, rd, rs);
        chk("low only", 1, rd[1]);
        axi_wr(`PTM_ADDR_AUTONEG, 32'h0000_0001, rs);
        repeat (3) @(posedge clk);
        chk("swing", 0, tx_high_swing);
        final_report;
    end
endmodule // tb
